// >>> shared/ras_acc_if.sv
// One arbitrated register access between the front end and the bit array
interface ras_acc_if;
  logic                         rd;
  logic                         wr;
  logic [ras_pkg::RAS_AW-1:0]   addr;
  logic [ras_pkg::RAS_WIDTH-1:0] wdata;
  logic [ras_pkg::RAS_WIDTH-1:0] rdata;

  modport master (output rd, output wr, output addr, output wdata, input rdata);
  modport slave  (input rd, input wr, input addr, input wdata, output rdata);
endinterface : ras_acc_if

// >>> shared/ras_pkg.sv
package ras_pkg;
  // Access types of one register bit
  typedef enum logic [2:0] {
    RAS_READ_ONLY,
    RAS_READ_CLEAR,
    RAS_WRITE_ONLY,
    RAS_WRITE_ONE_CLEAR,
    RAS_LATCH_LOW_STATUS,
    RAS_LATCH_HIGH_STATUS,
    RAS_SELF_CLEARING,
    RAS_RESERVED
  } ras_type_t;

  // Management paths that may reach the register space
  typedef enum logic [1:0] {
    RAS_SRC_SPI,
    RAS_SRC_I2C,
    RAS_SRC_INBAND,
    RAS_SRC_MIIM
  } ras_src_t;

  localparam int          RAS_WIDTH      = 16;
  localparam int          RAS_NREG       = 8;
  localparam int          RAS_AW         = 3;
  localparam int          RAS_NSRC       = 4;
  localparam logic [15:0] RAS_DATA_RESET = 16'h0000;
  localparam logic [15:0] RAS_WO_READ    = 16'h0000;
  localparam logic [15:0] RAS_RSVD_READ  = 16'h0000;
  localparam logic        RAS_LL_RESET   = 1'b1;
  localparam logic        RAS_LH_RESET   = 1'b0;
endpackage : ras_pkg

// >>> sim/ras_host.sv
module ras_host (
  // Clock and answer
  input wire logic        clk,
  input wire logic [3:0]  ack,
  input wire logic        busy_n,
  // Requests
  output logic [3:0]       req_rd,
  output logic [3:0]       req_wr,
  output logic [3:0][2:0]  req_addr,
  output logic [3:0][15:0] req_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {req_rd, req_wr, req_addr, req_wdata} = '0;
  task automatic access(input int s, input bit rd, input logic [2:0] a,
                        input logic [15:0] d, output bit got);
    @(posedge clk);
    req_rd[s]    <= rd;
    req_wr[s]    <= !rd;
    req_addr[s]  <= a;
    req_wdata[s] <= (a == 3'h7) ? 16'h0000 : d;
    got = 0;
    for (int i = 0; i < 6 && !got; i++) begin
      @(posedge clk);
      got = ack[s] && !busy_n;
    end
    // Released lines show a changed value, not the last one
    {req_rd[s], req_wr[s], req_addr[s], req_wdata[s]} <= {2'h0, ~a, ~d};
  endtask : access
endmodule : ras_host

// >>> sim/ras_regs_assertions.sv
module ras_regs_assertions #(
  parameter logic [7:0] PHY_MAP = 8'h0f
) (
  // Clock, requests and answer
  input wire logic            clk,
  input wire logic            rst,
  input wire logic [3:0]      req_rd,
  input wire logic [3:0]      req_wr,
  input wire logic [3:0][2:0] req_addr,
  input wire logic [3:0]      ack,
  input wire logic [15:0]     rdata,
  input wire logic            busy_n,
  input wire logic [127:0]    hw_val
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  a_one_grant: assert property ($onehot0(ack))
    else $error("two grants");
  a_spi_answer: assert property (
    !$past(rst) |-> ack[0] == $past(req_rd[0] || req_wr[0])) else $error("spi answer");
  a_i2c_waits: assert property (
    ack[1] |-> $past(!(req_rd[0] || req_wr[0]) && (req_rd[1] || req_wr[1])))
    else $error("i2c priority");
  a_ack_cause: assert property (|ack |-> $past(|(req_rd | req_wr)))
    else $error("ack without request");
  a_phy_only: assert property (ack[3] |-> PHY_MAP[$past(req_addr[3])])
    else $error("miim outside phy rows");
  a_busy_low: assert property (busy_n == !(|ack))
    else $error("busy level");
  a_rdata_holds: assert property (
    !$past(rst) && $past(req_rd) == 4'h0 |-> $stable(rdata)) else $error("rdata moved");
  a_live_read: assert property (
    !$past(rst) && $past(req_rd[0] && req_addr[0] == 3'h0) |-> rdata == $past(hw_val[15:0]))
    else $error("live read");
endmodule : ras_regs_assertions

bind ras_regs ras_regs_assertions #(.PHY_MAP(PHY_MAP)) ras_regs_assertions_i (
  .clk, .rst, .req_rd, .req_wr, .req_addr, .ack, .rdata, .busy_n, .hw_val);

// >>> sim/tb_register_access_semantics.sv
module tb_register_access_semantics;
  timeunit 1ns;
  timeprecision 1ps;
  typedef ras_pkg::ras_type_t ras_kind_t [128];
  logic             clk, rst, busy_n;
  logic [3:0]       req_rd, req_wr, ack;
  logic [3:0][2:0]  req_addr;
  logic [3:0][15:0] req_wdata;
  logic [15:0]      rdata, mrd;
  logic [127:0]     hw_val, hw_set, ctrl;
  logic [15:0]      m [8];
  logic [18:0]      q [$];
  bit               live;
  int               n_mismatch, comparisons;
  // Row r holds bits of access type r
  function automatic ras_kind_t kinds();
    ras_kind_t k;
    foreach (k[i]) k[i] = ras_pkg::ras_type_t'(i / 16);
    return k;
  endfunction : kinds
  ras_regs #(.KIND(kinds())) ras_regs_i (.clk, .rst, .req_rd, .req_wr, .req_addr, .req_wdata,
    .ack, .rdata, .busy_n, .hw_val, .hw_set, .ctrl);
  ras_host host_i (.clk, .ack, .busy_n, .req_rd, .req_wr, .req_addr, .req_wdata);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    hw_val <= {$urandom, $urandom, $urandom, $urandom};
    hw_set <= {4{$urandom & $urandom}};
  end
  always @(posedge clk) begin : model
    int g;
    logic [2:0] a;
    bit rd, wr;
    g = -1;
    for (int s = 3; s >= 0; s--)
      if (req_rd[s] || req_wr[s]) g = s;
    if (g == 3 && req_addr[3] > 3) g = -1;
    live = 1;
    a = (g >= 0) ? req_addr[g] : 3'h0;
    if (rst) begin
      foreach (m[r]) m[r] = (r == 4) ? 16'hffff : 16'h0000;
      mrd = 16'h0000;
      q.delete();
    end else begin
      if (g >= 0) q.push_back({g[1:0], req_rd[g],
        a == 0 ? hw_val[15:0] : (a == 2 || a == 7) ? 16'h0000 : m[a]});
      foreach (m[r]) begin
        rd = g >= 0 && a == r && req_rd[g];
        wr = g >= 0 && a == r && !req_rd[g];
        case (r)
          1: m[r] = (rd ? 16'h0000 : m[r]) | hw_set[16+:16];
          2: if (wr) m[r] = req_wdata[g];
          3: m[r] = (wr ? m[r] & ~req_wdata[g] : m[r]) | hw_set[48+:16];
          4: m[r] = rd ? hw_val[64+:16] : m[r] & hw_val[64+:16];
          5: m[r] = rd ? hw_val[80+:16] : m[r] | hw_val[80+:16];
          6: m[r] = (m[r] & ~hw_set[96+:16]) | (wr ? req_wdata[g] : 16'h0000);
          default: ;
        endcase
      end
    end
  end
  task automatic chk(input bit ok);
    comparisons++;
    if (!ok) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: design differs from model", $time);
    end
  endtask : chk
  always @(negedge clk) begin : judge
    logic [18:0] e;
    if (live) begin
      if (q.size() != 0) begin
        e = q.pop_front();
        if (e[16]) mrd = e[15:0];
        chk(ack === 4'(1 << e[18:17]) && busy_n === 1'b0);
      end else
        chk(ack === 4'h0 && busy_n === 1'b1);
      chk(rdata === mrd);
      chk(ctrl[47:32] === m[2]);
    end
  end
  task automatic final_report;
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report
  initial begin
    bit g0, g1;
    int r, s;
    void'($urandom(32'ha285));
    {rst, hw_val, hw_set} = {1'b1, 256'h0};
    repeat (2) begin
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (int i = 0; i < 150; i++) begin
        r = $urandom % 8;
        s = $urandom % 4;
        host_i.access(s, 1'($urandom), 3'(r), 16'($urandom), g0);
        chk(g0 === (s != 3 || r < 4));
      end
    end
    fork
      host_i.access(0, 1'b1, 3'h1, 16'h0000, g0);
      host_i.access(1, 1'b1, 3'h5, 16'h0000, g1);
    join
    chk(g0 && g1);
    final_report();
  end
endmodule : tb_register_access_semantics

// >>> verilog/ras_bit.sv
// One register bit with a selectable access type
module ras_bit #(
  parameter ras_pkg::ras_type_t KIND = ras_pkg::RAS_READ_ONLY
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Access
  input  wire logic rd,
  input  wire logic wr,
  input  wire logic wbit,
  // Hardware side
  input  wire logic hw_val,
  input  wire logic hw_set,
  // Read value
  output logic      rbit
);
  logic state;
  logic next_state;

  always_comb begin
    next_state = state;
    unique case (KIND)
      ras_pkg::RAS_READ_ONLY:         next_state = hw_val; // R01
      ras_pkg::RAS_READ_CLEAR: begin
        // Set wins over the read clear; read value taken from old state
        if (rd) next_state = 1'b0; // R02 R14
        if (hw_set) next_state = 1'b1;
      end
      ras_pkg::RAS_WRITE_ONLY:        if (wr) next_state = wbit; // R03
      ras_pkg::RAS_WRITE_ONE_CLEAR: begin
        if (wr && wbit) next_state = 1'b0; // R04
        if (hw_set) next_state = 1'b1;
      end
      ras_pkg::RAS_LATCH_LOW_STATUS: begin
        if (rd) next_state = hw_val; // R06 R14
        else if (!hw_val) next_state = 1'b0; // R05
      end
      ras_pkg::RAS_LATCH_HIGH_STATUS: begin
        if (rd) next_state = hw_val; // R08 R14
        else if (hw_val) next_state = 1'b1; // R07
      end
      ras_pkg::RAS_SELF_CLEARING: begin
        // Set by a written one, cleared when the action completes
        if (state && hw_set) next_state = 1'b0; // R09
        if (wr && wbit) next_state = 1'b1; // R09
      end
      ras_pkg::RAS_RESERVED:          next_state = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      if (KIND == ras_pkg::RAS_LATCH_LOW_STATUS) state <= ras_pkg::RAS_LL_RESET;
      else state <= ras_pkg::RAS_LH_RESET;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    unique case (KIND)
      // Live value, so a read returns the condition of the access cycle
      ras_pkg::RAS_READ_ONLY:  rbit = hw_val; // R01
      ras_pkg::RAS_WRITE_ONLY: rbit = 1'b0; // R03
      ras_pkg::RAS_RESERVED:   rbit = 1'b0;
      default:                 rbit = state;
    endcase
  end
endmodule : ras_bit

// >>> verilog/ras_regs.sv
// Behaviour
// R01: read_only bits return live value; writes ignored.
// R02: read_clear bits return contents, then clear; writes ignored.
// R03: write_only bits accept writes; reads return meaningless data.
// R04: write_one_clear bits clear on written one; zero leaves them.
// R05: latch_low_status bit stays low after condition low until read.
// R06: reading latch_low_status releases latch; bit follows live high again.
// R07: latch_high_status bit stays high after condition high until read.
// R08: reading latch_high_status releases latch; bit follows live low again.
// R09: self_clearing bits clear themselves, ignore zero writes, stay readable.
// R10: software writes zeros to reserved bits, ignores their read value.
// R11: whole register space reachable over SPI, I2C or in-band frames.
// R12: PHY registers reachable through the MIIM management interface.
// R13: names ending _n are asserted low, both sides.
// R14: latch release takes effect after the read data is captured.
module ras_regs #(
  // Access type of each bit, row by row (index reg*16+bit)
  parameter ras_pkg::ras_type_t KIND [ras_pkg::RAS_NREG*ras_pkg::RAS_WIDTH] =
    '{default: ras_pkg::RAS_READ_ONLY},
  // Registers reachable by the MIIM path (PHY registers)
  parameter logic [ras_pkg::RAS_NREG-1:0] PHY_MAP = 8'h0f
) (
  // Clock and reset
  input  wire logic                                            clk,
  input  wire logic                                            rst,
  // Requests from the management paths, one per ras_src_t
  input  wire logic [ras_pkg::RAS_NSRC-1:0]                    req_rd,
  input  wire logic [ras_pkg::RAS_NSRC-1:0]                    req_wr,
  input  wire logic [ras_pkg::RAS_NSRC-1:0][ras_pkg::RAS_AW-1:0] req_addr,
  input  wire logic [ras_pkg::RAS_NSRC-1:0][ras_pkg::RAS_WIDTH-1:0] req_wdata,
  // Answer
  output logic [ras_pkg::RAS_NSRC-1:0]                         ack,
  output logic [ras_pkg::RAS_WIDTH-1:0]                        rdata,
  output logic                                                 busy_n,
  // Hardware status
  input  wire logic [ras_pkg::RAS_NREG*ras_pkg::RAS_WIDTH-1:0] hw_val,
  input  wire logic [ras_pkg::RAS_NREG*ras_pkg::RAS_WIDTH-1:0] hw_set,
  // Register contents for the block's own logic; write-only bits hold the written value
  output logic [ras_pkg::RAS_NREG*ras_pkg::RAS_WIDTH-1:0]      ctrl
);
  localparam int NB = ras_pkg::RAS_NREG * ras_pkg::RAS_WIDTH;

  ras_acc_if acc ();

  logic [ras_pkg::RAS_NSRC-1:0]   grant;
  logic [ras_pkg::RAS_NSRC-1:0]   next_ack;
  logic [ras_pkg::RAS_WIDTH-1:0]  next_rdata;
  logic                           next_busy_n;
  logic [NB-1:0]                  rbits;
  logic [NB-1:0]                  next_ctrl;

  // Fixed priority SPI > I2C > in-band > MIIM; MIIM limited to PHY rows
  always_comb begin
    grant     = '0;
    acc.rd    = 1'b0;
    acc.wr    = 1'b0;
    acc.addr  = '0;
    acc.wdata = '0;
    for (int s = ras_pkg::RAS_NSRC - 1; s >= 0; s--) begin
      if (req_rd[s] || req_wr[s]) begin
        grant     = '0;
        grant[s]  = 1'b1;
        acc.addr  = req_addr[s];
        acc.wdata = req_wdata[s];
        acc.rd    = req_rd[s]; // R11
        acc.wr    = req_wr[s] && !req_rd[s]; // R11
      end
    end
    if (grant[ras_pkg::RAS_SRC_MIIM] && !PHY_MAP[acc.addr]) begin
      acc.rd = 1'b0; // R12
      acc.wr = 1'b0; // R12
    end
  end

  genvar g;
  generate
    for (g = 0; g < NB; g++) begin : g_bit
      localparam int R = g / ras_pkg::RAS_WIDTH;
      logic sel;
      assign sel = (acc.addr == R[ras_pkg::RAS_AW-1:0]);
      ras_bit #(.KIND(KIND[g])) u_bit (
        .clk    (clk),
        .rst    (rst),
        .rd     (acc.rd && sel),
        .wr     (acc.wr && sel),
        .wbit   (acc.wdata[g % ras_pkg::RAS_WIDTH]),
        .hw_val (hw_val[g]),
        .hw_set (hw_set[g]),
        .rbit   (rbits[g])
      );
    end
  endgenerate

  always_comb begin
    acc.rdata   = rbits[acc.addr*ras_pkg::RAS_WIDTH +: ras_pkg::RAS_WIDTH];
    next_ack    = grant & {ras_pkg::RAS_NSRC{acc.rd || acc.wr}};
    // Captured in the same edge that releases latches and clears bits
    next_rdata  = acc.rd ? acc.rdata : rdata; // R14
    next_busy_n = !(acc.rd || acc.wr); // R13
    next_ctrl   = rbits;
    for (int i = 0; i < NB; i++) begin
      if (KIND[i] == ras_pkg::RAS_WRITE_ONLY) next_ctrl[i] = ctrl[i];
    end
    if (acc.wr) begin
      for (int b = 0; b < ras_pkg::RAS_WIDTH; b++) begin
        if (KIND[acc.addr*ras_pkg::RAS_WIDTH + b] == ras_pkg::RAS_WRITE_ONLY) begin
          next_ctrl[acc.addr*ras_pkg::RAS_WIDTH + b] = acc.wdata[b]; // R03
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ack    <= '0;
      rdata  <= ras_pkg::RAS_DATA_RESET;
      busy_n <= 1'b1;
      ctrl   <= '0;
    end else begin
      ack    <= next_ack;
      rdata  <= next_rdata;
      busy_n <= next_busy_n;
      ctrl   <= next_ctrl;
    end
  end
endmodule : ras_regs
